// ---- src/acsr_regs.sv ----
// Implementation choice: register access over APB.
`timescale 1ns/1ps
// ----------------------------------------
// Converter control and status registers, APB slave
// ----------------------------------------
module acsr_regs
  import acsr_pkg::*;
#(
  parameter int NUM_GPIO = 4  // General-purpose pins that may carry power-down
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_GPIO-1:0] gpio_in,  // Pins, asynchronous
  input wire logic ovr_raw,                 // Core overrange event, pclk domain
  input wire logic sync_event,              // Sync detected, pclk domain
  output acsr_ctl_s ctl,
  output logic ovr_ind,
  output logic sync_seen_flag,
  output logic cfg_ready
);

  if (NUM_GPIO < 1 || NUM_GPIO > 31) begin : g_bad_gpio
    $error("acsr_regs: NUM_GPIO must be 1 to 31");
  end

  // ----------------------------------------
  // Decode helper
  // ----------------------------------------
  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_CFG_READY, IDX_SOFT_RST, IDX_PDN, IDX_SYNC_CLR, IDX_TERM,
      IDX_OVR_CTL, IDX_OVR_LEN, IDX_STATUS, IDX_OUT_CFG, IDX_GPIO_FN: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [IDX_W-1:0] idx;            // Word index of the access
  logic acc;                        // First access-phase cycle
  logic wr_en;                      // Write takes effect this edge
  logic [6:0] fuse_cnt_reg;         // Fuse load countdown
  logic [6:0] fuse_cnt_next;
  logic cfg_rdy_reg;                // Fuses applied
  logic cfg_rdy_next;
  logic soft_rst_reg;               // Self-clearing soft reset
  logic soft_rst_next;
  logic pdn_reg;                    // Global power-down bit
  logic pdn_next;
  logic sclr_reg;                   // Stored sync clear bit
  logic sclr_next;
  logic sclr_pulse;                 // Write of 1 to the clear bit
  logic [1:0] term_reg;             // Input termination selects
  logic [1:0] term_next;
  logic ovr_sticky_reg;             // Overrange latch mode
  logic ovr_sticky_next;
  logic [1:0] ovr_clr_reg;          // Overrange clear field
  logic [1:0] ovr_clr_next;
  logic ovr_clr_pulse;              // Clear code written
  logic [7:0] ovr_len_reg;          // Stretch length
  logic [7:0] ovr_len_next;
  logic [7:0] out_cfg_reg;          // Output configuration
  logic [7:0] out_cfg_next;
  logic [4:0] gpio_fn_reg;          // Pin used for power-down, 0 none
  logic [4:0] gpio_fn_next;
  logic sync_reg;                   // Sync-seen flag
  logic sync_next;
  logic [NUM_GPIO-1:0] gpio_s1;     // Synchroniser first stage
  logic [NUM_GPIO-1:0] gpio_s2;     // Synchroniser second stage
  logic gpio_pdn;                   // Selected pin level
  acsr_ctl_s ctl_reg;
  acsr_ctl_s ctl_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pslverr_reg;
  logic [7:0] rd_byte;              // Read mux result

  assign idx = paddr[APB_AW-1:2];
  // One wait state: pready rises on the second access cycle
  assign acc = psel & penable & ~pready_reg;
  assign wr_en = psel & penable & pwrite & pready_reg;
  assign sclr_pulse = wr_en && idx == IDX_SYNC_CLR && pwdata[BIT_SYNC_CLR];
  assign ovr_clr_pulse = wr_en && idx == IDX_OVR_CTL &&
    pwdata[BIT_OVR_CLR_LO+1:BIT_OVR_CLR_LO] == OVR_CLR_CODE;

  // ----------------------------------------
  // Fuse load after hardware reset
  // ----------------------------------------
  // Soft reset does not restart it: fuses are loaded once per power-up reset
  always_comb begin
    fuse_cnt_next = fuse_cnt_reg;
    if (fuse_cnt_reg != '0) begin
      fuse_cnt_next = fuse_cnt_reg - 7'h01;
    end
    cfg_rdy_next = cfg_rdy_reg | (fuse_cnt_reg == '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_cnt_reg <= 7'(FUSE_LOAD_CYC - 1);
      cfg_rdy_reg <= 1'b0;
    end else begin
      fuse_cnt_reg <= fuse_cnt_next;
      cfg_rdy_reg <= cfg_rdy_next;
    end
  end

  // ----------------------------------------
  // Register file next state
  // ----------------------------------------
  // Reserved bits are not stored, so they always read zero
  always_comb begin
    soft_rst_next = 1'b0;
    pdn_next = pdn_reg;
    sclr_next = sclr_reg;
    term_next = term_reg;
    ovr_sticky_next = ovr_sticky_reg;
    ovr_clr_next = ovr_clr_reg;
    ovr_len_next = ovr_len_reg;
    out_cfg_next = out_cfg_reg;
    gpio_fn_next = gpio_fn_reg;
    if (soft_rst_reg) begin
      // Every writable register back to its default
      pdn_next = 1'b0;
      sclr_next = 1'b0;
      term_next = 2'h0;
      ovr_sticky_next = 1'b0;
      ovr_clr_next = 2'h0;
      ovr_len_next = OVR_LEN_RST;
      out_cfg_next = OUT_CFG_RST;
      gpio_fn_next = GPIO_FN_RST;
    end else if (wr_en) begin
      unique case (idx)
        IDX_SOFT_RST: soft_rst_next = pwdata[BIT_SOFT_RST];
        IDX_PDN: pdn_next = pwdata[BIT_PDN];
        IDX_SYNC_CLR: sclr_next = pwdata[BIT_SYNC_CLR];
        IDX_TERM: term_next = pwdata[1:0];
        IDX_OVR_CTL: begin
          ovr_sticky_next = pwdata[BIT_OVR_STICKY];
          ovr_clr_next = pwdata[BIT_OVR_CLR_LO+1:BIT_OVR_CLR_LO];
        end
        IDX_OVR_LEN: ovr_len_next = pwdata[7:0];
        IDX_OUT_CFG: begin
          out_cfg_next = '0;
          out_cfg_next[BIT_OUT_TERM] = pwdata[BIT_OUT_TERM];
          out_cfg_next[BIT_HALF_SWING] = pwdata[BIT_HALF_SWING];
          out_cfg_next[BIT_CH_EXCH] = pwdata[BIT_CH_EXCH];
        end
        IDX_GPIO_FN: gpio_fn_next = pwdata[4:0];
        default: begin
          // Ready bit and status are read only; unmapped writes are dropped
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    sync_next = sync_event | (sync_reg & ~sclr_pulse & ~soft_rst_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_rst_reg <= 1'b0;
      pdn_reg <= 1'b0;
      sclr_reg <= 1'b0;
      term_reg <= 2'h0;
      ovr_sticky_reg <= 1'b0;
      ovr_clr_reg <= 2'h0;
      ovr_len_reg <= OVR_LEN_RST;
      out_cfg_reg <= OUT_CFG_RST;
      gpio_fn_reg <= GPIO_FN_RST;
      sync_reg <= 1'b0;
    end else begin
      soft_rst_reg <= soft_rst_next;
      pdn_reg <= pdn_next;
      sclr_reg <= sclr_next;
      term_reg <= term_next;
      ovr_sticky_reg <= ovr_sticky_next;
      ovr_clr_reg <= ovr_clr_next;
      ovr_len_reg <= ovr_len_next;
      out_cfg_reg <= out_cfg_next;
      gpio_fn_reg <= gpio_fn_next;
      sync_reg <= sync_next;
    end
  end

  // ----------------------------------------
  // Pin synchroniser and power-down select
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_s1 <= '0;
      gpio_s2 <= '0;
    end else begin
      gpio_s1 <= gpio_in;
      gpio_s2 <= gpio_s1;
    end
  end

  // Only the second stage is looked at
  always_comb begin
    gpio_pdn = 1'b0;
    for (int i = 0; i < NUM_GPIO; i++) begin
      if (gpio_fn_reg == 5'(i + 1)) begin
        gpio_pdn = gpio_s2[i];
      end
    end
  end

  // ----------------------------------------
  // Overrange conditioning
  // ----------------------------------------
  acsr_ovr_stretch #(
    .LEN_W(8)
  ) u_acsr_ovr_stretch (
    .pclk(pclk),
    .presetn(presetn),
    .ovr_raw(ovr_raw),
    .sticky(ovr_sticky_reg),
    .len(ovr_len_reg),
    .clr(ovr_clr_pulse),
    .soft_clr(soft_rst_reg),
    .ovr_ind(ovr_ind),
    .cnt_mon()
  );

  // ----------------------------------------
  // Control outputs and APB answer
  // ----------------------------------------
  always_comb begin
    ctl_next.global_power_down = pdn_reg | gpio_pdn;
    ctl_next.term_b = term_reg[BIT_TERM_B];
    ctl_next.term_a = term_reg[BIT_TERM_A];
    ctl_next.out_term = out_cfg_reg[BIT_OUT_TERM];
    ctl_next.half_swing = out_cfg_reg[BIT_HALF_SWING];
    ctl_next.chan_exchange = out_cfg_reg[BIT_CH_EXCH];
    rd_byte = 8'h00;
    case (idx)
      IDX_CFG_READY: rd_byte[BIT_CFG_READY] = cfg_rdy_reg;
      IDX_SOFT_RST: rd_byte[BIT_SOFT_RST] = soft_rst_reg;
      IDX_PDN: rd_byte[BIT_PDN] = pdn_reg;
      IDX_SYNC_CLR: rd_byte[BIT_SYNC_CLR] = sclr_reg;
      IDX_TERM: rd_byte[1:0] = term_reg;
      IDX_OVR_CTL: rd_byte[2:0] = {ovr_clr_reg, ovr_sticky_reg};
      IDX_OVR_LEN: rd_byte = ovr_len_reg;
      IDX_STATUS: rd_byte[BIT_ST_SYNC:BIT_ST_OVR] = {sync_reg, ovr_ind};
      IDX_OUT_CFG: rd_byte = out_cfg_reg;
      IDX_GPIO_FN: rd_byte[4:0] = gpio_fn_reg;
      default: rd_byte = 8'h00;
    endcase
    prdata_next = prdata_reg;
    if (acc) begin
      prdata_next = (pwrite) ? 32'h0000_0000 : {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= '0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      prdata_reg <= prdata_next;
      pready_reg <= acc;
      pslverr_reg <= acc & ~is_mapped(idx);  // Unmapped answers with an error
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign ctl = ctl_reg;
  assign sync_seen_flag = sync_reg;
  assign cfg_ready = cfg_rdy_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_cfg_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (fuse_cnt_reg != '0) |-> !cfg_rdy_reg)
    else $error("ready bit set during fuse load");
  a_cfg_ready_set: assert property (@(posedge pclk) disable iff (!presetn)
    (fuse_cnt_reg == '0) |=> cfg_rdy_reg)
    else $error("ready bit not set after fuse load");
  a_soft_rst_self: assert property (@(posedge pclk) disable iff (!presetn)
    soft_rst_reg |=> (!soft_rst_reg && term_reg == 2'h0 && !pdn_reg &&
      out_cfg_reg == OUT_CFG_RST && ovr_len_reg == OVR_LEN_RST))
    else $error("soft reset did not restore and clear");
  a_pdn_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == IDX_PDN && pwdata[BIT_PDN]) |=> ##1 ctl.global_power_down)
    else $error("power-down bit did not reach output");
  a_gpio_pdn: assert property (@(posedge pclk) disable iff (!presetn)
    (gpio_fn_reg == 5'h01 && gpio_in[0]) ##1 (gpio_fn_reg == 5'h01) [*2] |=> ctl.global_power_down)
    else $error("selected pin did not power down");
  a_sync_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (sclr_pulse && !sync_event) |=> !sync_seen_flag)
    else $error("sync-seen flag not cleared");
  a_sync_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    sync_event |=> sync_seen_flag)
    else $error("sync event lost");
  a_term_select: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == IDX_TERM && !soft_rst_reg) |=> ##1
      ({ctl.term_b, ctl.term_a} == $past(pwdata[1:0], 2)))
    else $error("termination select mismatch");
  a_out_cfg_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == IDX_OUT_CFG && !soft_rst_reg) |=> ##1
      (ctl.out_term == $past(pwdata[7], 2) && ctl.half_swing == $past(pwdata[5], 2)))
    else $error("output configuration mismatch");
  a_exchange_reset: assert property (@(posedge pclk) disable iff (!presetn)
    soft_rst_reg |=> ##1 ctl.chan_exchange)
    else $error("channel exchange not back to normal");
  c_soft_reset: cover property (@(posedge pclk) disable iff (!presetn) soft_rst_reg);
  c_sync_clear: cover property (@(posedge pclk) disable iff (!presetn)
    sync_seen_flag ##1 sclr_pulse);
  c_gpio_pdn: cover property (@(posedge pclk) disable iff (!presetn) gpio_pdn && !pdn_reg);

endmodule // acsr_regs

// ---- src/acsr_pkg.sv ----
// Overview of operation
// - Ready bit reads 1 after fuse load.
// - Soft reset restores defaults, then self clears.
// - Power-down bit forces global power-down.
// - Selected GPIO pin also forces power-down.
// - Clear bit write resets sync-seen flag.
// - Channel B termination: 0=100 ohm, 1=200.
// - Channel A termination: 0=100 ohm, 1=200.
// - Overrange follows stretch, or latches when sticky.
// - Clear code 0x2 clears latched overrange.
// - Overrange pulse lasts length plus one.
// - Output termination bit selects 100 ohm.
// - Reduced-swing bit halves output swing.
// - Channel exchange resets 1; 0 exchanges channels.
package acsr_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int APB_AW = 14;  // Byte address width
  localparam int IDX_W = 12;   // Register index width

  // ----------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------
  localparam logic [11:0] IDX_CFG_READY = 12'h025;
  localparam logic [11:0] IDX_SOFT_RST = 12'h100;
  localparam logic [11:0] IDX_PDN = 12'h101;
  localparam logic [11:0] IDX_SYNC_CLR = 12'h102;
  localparam logic [11:0] IDX_TERM = 12'h104;
  localparam logic [11:0] IDX_OVR_CTL = 12'h10A;
  localparam logic [11:0] IDX_OVR_LEN = 12'h10B;
  localparam logic [11:0] IDX_STATUS = 12'h10C;
  localparam logic [11:0] IDX_OUT_CFG = 12'h110;
  localparam logic [11:0] IDX_GPIO_FN = 12'h146;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_CFG_READY = 4;
  localparam int BIT_SOFT_RST = 0;
  localparam int BIT_PDN = 4;
  localparam int BIT_SYNC_CLR = 6;
  localparam int BIT_TERM_A = 0;
  localparam int BIT_TERM_B = 1;
  localparam int BIT_OVR_STICKY = 0;
  localparam int BIT_OVR_CLR_LO = 1;
  localparam int BIT_OUT_TERM = 7;
  localparam int BIT_HALF_SWING = 5;
  localparam int BIT_CH_EXCH = 1;
  localparam int BIT_ST_OVR = 0;
  localparam int BIT_ST_SYNC = 1;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [7:0] OVR_LEN_RST = 8'h00;
  localparam logic [1:0] OVR_CLR_CODE = 2'h2;
  localparam logic [7:0] OUT_CFG_RST = 8'h02;
  localparam logic [4:0] GPIO_FN_RST = 5'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FUSE_LOAD_NS = 1000;  // Modelled fuse load time
  // Least time, rounded up to whole cycles
  localparam int FUSE_LOAD_CYC = (FUSE_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Analog and output controls leaving the block
  typedef struct packed {
    logic global_power_down;        // Global power-down
    logic term_b;         // Channel B termination select
    logic term_a;         // Channel A termination select
    logic out_term;       // Output termination 100 ohm
    logic half_swing;     // Reduced output swing
    logic chan_exchange;  // 1 normal, 0 exchanged
  } acsr_ctl_s;

endpackage

// ---- src/acsr_ovr_stretch.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Overrange pulse stretcher and latch
// ----------------------------------------
module acsr_ovr_stretch
  import acsr_pkg::*;
#(
  parameter int LEN_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ovr_raw,          // Overrange event from converter core
  input wire logic sticky,           // Latch mode
  input wire logic [LEN_W-1:0] len,  // Stretch length minus one
  input wire logic clr,              // Clear pulse for latched state
  input wire logic soft_clr,         // Soft reset pulse
  output logic ovr_ind,              // Overrange indicator
  output logic [LEN_W-1:0] cnt_mon   // Remaining stretch count
);

  logic [LEN_W-1:0] cnt_reg;  // Cycles left after the current one
  logic [LEN_W-1:0] cnt_next;
  logic ind_reg;
  logic ind_next;

  if (LEN_W < 1 || LEN_W > 16) begin : g_bad_len
    $error("acsr_ovr_stretch: LEN_W out of range");
  end

  // Next state: a new event restarts the stretch
  always_comb begin
    cnt_next = cnt_reg;
    ind_next = ind_reg;
    if (ovr_raw) begin
      cnt_next = len;
    end else if (soft_clr) begin
      cnt_next = '0;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
    if (sticky) begin
      // Event wins over a clear in the same cycle
      ind_next = ovr_raw | (ind_reg & ~clr & ~soft_clr);
    end else begin
      // High for len+1 cycles after the last event
      ind_next = ovr_raw | ((cnt_reg != '0) & ~soft_clr);
    end
  end

  // Registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      ind_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      ind_reg <= ind_next;
    end
  end

  assign ovr_ind = ind_reg;
  assign cnt_mon = cnt_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ovr_stretch_len: assert property (@(posedge pclk) disable iff (!presetn)
    (ovr_raw && !sticky) |=> (ind_reg && cnt_reg == $past(len)))
    else $error("stretch did not load length");
  a_ovr_stretch_end: assert property (@(posedge pclk) disable iff (!presetn)
    (!sticky && !ovr_raw && cnt_reg == '0) |=> !ind_reg)
    else $error("stretched overrange did not end");
  a_ovr_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (sticky && ind_reg && !clr && !soft_clr) |=> ind_reg)
    else $error("latched overrange dropped");
  a_ovr_clear_code: assert property (@(posedge pclk) disable iff (!presetn)
    (sticky && clr && !ovr_raw) |=> !ind_reg)
    else $error("latched overrange not cleared");
  c_ovr_sticky_clear: cover property (@(posedge pclk) disable iff (!presetn)
    sticky && ind_reg && clr);

endmodule // acsr_ovr_stretch

// ---- test/acsr_regs_tb_top.sv ----
`timescale 1ns/1ps
module acsr_regs_tb_top;
  import acsr_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic pclk = 1'b0;  // 100 MHz
  logic presetn = 1'b0;  // Held low for 16 cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] gpio_in = 4'h0;  // Power-down candidates
  logic ovr_raw = 1'b0;
  logic sync_event = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  acsr_ctl_s ctl;
  logic ovr_ind;
  logic sync_seen_flag;
  logic cfg_ready;
  int fail_count = 0;
  int n_tests = 0;
  logic [31:0] rd;  // Data of last transfer
  logic err;  // Error flag of last transfer

  always #5 pclk = ~pclk;

  acsr_regs #(.NUM_GPIO(4)) u_acsr_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_in(gpio_in), .ovr_raw(ovr_raw), .sync_event(sync_event), .ctl(ctl),
    .ovr_ind(ovr_ind), .sync_seen_flag(sync_seen_flag), .cfg_ready(cfg_ready)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compare one value, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Counts, verdict and end of run
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One APB transfer; no wait-state count assumed, bounded by a timeout
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Let n edges pass, then look after their updates
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_boot();
    int n;
    #1;
    chk(cfg_ready, 0);
    apb(1'b0, 14'h0094, 0);
    chk(rd, 0);
    for (n = 0; n < 200 && cfg_ready !== 1'b1; n++) @(posedge pclk);
    if (cfg_ready !== 1'b1) begin
      fail_count++;
      results();
    end
    apb(1'b0, 14'h0094, 0);
    chk(rd, 32'h10);
    apb(1'b0, 14'h0410, 0);
    chk(rd, 0);
    apb(1'b0, 14'h0428, 0);
    chk(rd, 0);
    apb(1'b0, 14'h0440, 0);
    chk(rd, 32'h02);
    chk(ctl.chan_exchange, 1);
    apb(1'b0, 14'h07FC, 0);
    chk(err, 1);
    chk(rd, 0);
    $display("boot done");
  endtask

  task automatic t_ctl();
    apb(1'b1, 14'h0410, 32'h03);
    settle(3);
    chk({ctl.term_b, ctl.term_a}, 2'h3);
    apb(1'b1, 14'h0410, 32'h01);
    settle(3);
    chk({ctl.term_b, ctl.term_a}, 2'h1);
    apb(1'b1, 14'h0404, 32'h10);
    settle(3);
    chk(ctl.global_power_down, 1);
    apb(1'b1, 14'h0404, 32'h00);
    settle(3);
    chk(ctl.global_power_down, 0);
    apb(1'b1, 14'h0518, 32'h01);
    @(posedge pclk);
    gpio_in <= 4'h1;
    settle(5);
    chk(ctl.global_power_down, 1);
    @(posedge pclk);
    gpio_in <= 4'h2;  // Unselected pin must not power down
    settle(5);
    chk(ctl.global_power_down, 0);
    apb(1'b1, 14'h0440, 32'hA0);
    settle(3);
    chk({ctl.out_term, ctl.half_swing, ctl.chan_exchange}, 3'h6);
    apb(1'b0, 14'h0440, 0);
    chk(rd, 32'hA0);
    $display("controls done");
  endtask

  task automatic t_sync();
    @(posedge pclk);
    sync_event <= 1'b1;
    @(posedge pclk);
    sync_event <= 1'b0;
    settle(2);
    chk(sync_seen_flag, 1);
    apb(1'b1, 14'h0408, 32'h00);
    settle(2);
    chk(sync_seen_flag, 1);
    apb(1'b1, 14'h0408, 32'h40);
    settle(2);
    chk(sync_seen_flag, 0);
    $display("sync done");
  endtask

  // Stretch length 0 and 3, counting high cycles of the indicator
  task automatic t_ovr();
    int cnt;
    int k;
    for (k = 0; k < 4; k += 3) begin
      apb(1'b1, 14'h042C, 32'(k));
      @(posedge pclk);
      ovr_raw <= 1'b1;
      @(posedge pclk);
      ovr_raw <= 1'b0;
      #1;
      cnt = 0;
      repeat (20) begin
        if (ovr_ind === 1'b1) cnt++;
        settle(1);
      end
      chk(cnt, k + 1);
    end
    apb(1'b1, 14'h0428, 32'h01);
    @(posedge pclk);
    ovr_raw <= 1'b1;
    @(posedge pclk);
    ovr_raw <= 1'b0;
    settle(20);
    chk(ovr_ind, 1);
    apb(1'b0, 14'h0430, 0);
    chk(rd[0], 1);
    apb(1'b1, 14'h0428, 32'h05);
    settle(2);
    chk(ovr_ind, 0);
    $display("overrange done");
  endtask

  task automatic t_soft();
    apb(1'b1, 14'h0410, 32'h03);
    apb(1'b1, 14'h0400, 32'h01);
    settle(3);
    apb(1'b0, 14'h0410, 0);
    chk(rd, 0);
    apb(1'b0, 14'h0400, 0);
    chk(rd, 0);
    apb(1'b0, 14'h0440, 0);
    chk(rd, 32'h02);
    apb(1'b0, 14'h042C, 0);
    chk(rd, 0);
    chk({ctl.term_b, ctl.term_a, cfg_ready}, 3'h1);
    $display("soft reset done");
  endtask

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_boot();
    t_ctl();
    t_sync();
    t_ovr();
    t_soft();
    results();
  end

  // Whole run is far below this; reaching it means a hang
  initial begin
    #200000;
    fail_count++;
    results();
  end
endmodule  // acsr_regs_tb_top
